// File: hdl/crop_position_stage.v
// Staged signed 10-bit cropping position: upper bits held until the lower register is written.
`timescale 1ns/1ps
`include "picture_ctrl_map.vh"

module crop_position_stage #(
	parameter LOWER_MASK = 8'h03	// Writable bits of the lower register.
) (
	input  wire       clk_i,	// System clock.
	input  wire       reset_i,	// Synchronous reset, active high.
	input  wire       wr_upper_i,	// Write strobe of the upper register.
	input  wire       wr_lower_i,	// Write strobe of the lower register.
	input  wire [7:0] wdata_i,	// Write data.
	output reg  [7:0] upper_r,	// Staged upper bits 9:2, as read back.
	output reg  [7:0] lower_r,	// Lower register, as read back.
	output reg  [9:0] position_r	// Applied signed position.
);

	// ------------------------------------------------------------------
	// Staging and apply
	// ------------------------------------------------------------------
	// The upper byte alone never changes the applied value, so a half
	// written position cannot reach the video timing.
	always @(posedge clk_i) begin
		if (reset_i) begin
			upper_r    <= `RST_CROP_UPPER;
			lower_r    <= `RST_CROP_LOWER;
			position_r <= `RST_CROP_POSITION;
		end else begin
			if (wr_upper_i) begin
				upper_r <= wdata_i;
			end
			if (wr_lower_i) begin
				lower_r    <= wdata_i & LOWER_MASK;
				position_r <= {upper_r, wdata_i[1:0]};
			end
		end
	end

endmodule // crop_position_stage

// File: hdl/picture_ctrl_map.vh
// Register offsets, field positions, masks and reset values of the picture control bank.
`ifndef PICTURE_CTRL_MAP_VH
`define PICTURE_CTRL_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_LUMA_CONTROL_TWO     8'h08
`define OFS_BRIGHTNESS_LEVEL     8'h09
`define OFS_COLOUR_SATURATION    8'h0a
`define OFS_HUE_PHASE            8'h0b
`define OFS_CONTRAST_LEVEL       8'h0c
`define OFS_OUTPUT_FORMAT_SELECT 8'h0d
`define OFS_LUMA_CONTROL_THREE   8'h0f
`define OFS_SHARED_PIN_CONFIG    8'h0f
`define OFS_CROP_START_UPPER     8'h11
`define OFS_CROP_START_LOWER     8'h12
`define OFS_CROP_STOP_UPPER      8'h13
`define OFS_CROP_STOP_LOWER      8'h14
`define OFS_GENLOCK_RTC_CONTROL  8'h15

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_LUMA_CONTROL_TWO     8'h00
`define RST_BRIGHTNESS_LEVEL     8'h80
`define RST_COLOUR_SATURATION    8'h80
`define RST_HUE_PHASE            8'h00
`define RST_CONTRAST_LEVEL       8'h80
`define RST_OUTPUT_FORMAT_SELECT 8'h47
`define RST_SHARED_PIN_CONFIG    8'h08
`define RST_CROP_UPPER           8'h00
`define RST_CROP_LOWER           8'h00
`define RST_GENLOCK_RTC_CONTROL  8'h05
`define RST_CROP_POSITION        10'h000

// ----------------------------------------------------------------------
// Writable-bit masks (reserved bits read as zero)
// ----------------------------------------------------------------------
`define MSK_LUMA_CONTROL_TWO     8'h4c
`define MSK_OUTPUT_FORMAT_SELECT 8'h7f
`define MSK_SHARED_PIN_CONFIG    8'h7f
`define MSK_CROP_START_LOWER     8'h07
`define MSK_CROP_STOP_LOWER      8'h03
`define MSK_GENLOCK_RTC_CONTROL  8'h05

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_LUMA_TRAP_SEL        6
`define FLD_PEAK_GAIN_HI         3
`define FLD_PEAK_GAIN_LO         2
`define BIT_EXT_RANGE            6
`define BIT_UV_TWOS              5
`define FLD_BYPASS_HI            4
`define FLD_BYPASS_LO            3
`define FLD_FORMAT_HI            2
`define FLD_FORMAT_LO            0
`define FLD_STOPBAND_HI          1
`define FLD_STOPBAND_LO          0
`define BIT_FIELD_PIN_LOCK       6
`define BIT_VSYNC_PIN_LOCK       5
`define BIT_PAL_PIN_LOCK         4
`define BIT_FIELD_PIN_GENLOCK    3
`define BIT_VSYNC_PIN_PAL        2
`define BIT_GP_PIN_ALT           1
`define BIT_CLK_PIN_PIXEL        0
`define BIT_ACTIVE_VIDEO_FLAG_OFF_IN_VERTICAL_BLANK_OUT     2
`define BIT_OSC_LSB_FORCE        2
`define BIT_RTC_SELECT           0

// ----------------------------------------------------------------------
// Encodings and code ranges
// ----------------------------------------------------------------------
`define BYPASS_NORMAL            2'h0
`define BYPASS_DECIMATION        2'h1
`define BYPASS_RAW_ADC           2'h2
`define FORMAT_DISCRETE_SYNC     3'h0
`define FORMAT_EMBEDDED_SYNC     3'h7
`define RANGE_Y_MIN_601          8'h10
`define RANGE_Y_MAX_601          8'heb
`define RANGE_C_MIN_601          8'h10
`define RANGE_C_MAX_601          8'hf0
`define RANGE_MIN_EXT            8'h01
`define RANGE_MAX_EXT            8'hfe
`define GAIN_X2_ZERO             3'h0
`define GAIN_X2_HALF             3'h1
`define GAIN_X2_ONE              3'h2
`define GAIN_X2_TWO              3'h4
`define CHROMA_OFFSET            8'h80

`endif

// File: hdl/picture_ctrl_regs.v
// Picture control register bank of the video decoder, with shared-pin routing.
//
// Behaviour
// - Bit 6 picks comb or chroma trap
// - Peaking gain codes give 0, 0.5, 1, 2
// - Brightness 8 bits, reset value 128
// - Saturation 8 bits, reset value 128
// - Hue signed phase rotation, reset zero
// - Contrast 8 bits, reset value 128
// - Range bit picks 601 or extended limits
// - UV format offset binary or two's complement
// - Bypass selects normal, decimation or raw data
// - Format 000 discrete, 111 embedded sync
// - Stopband field picks one of four notches
// - Field pin: genlock, field ID or lock
// - Vsync pin: vsync, PAL flag or lock
// - General pin: interrupt, general or vblank
// - Clock pin: sample clock or pixel clock
// - Start position signed ten bits, default zero
// - Start applied only when lower register written
// - Stop applied only when lower register written
// - Bit 2 blanks active video in vblank
// - Bit 2 forces oscillator increment LSB
// - Bit 0 picks genlock or real-time format
`timescale 1ns/1ps
`include "picture_ctrl_map.vh"

module picture_ctrl_regs (
	input  wire       CLK_SYS_I,			// System clock, 20 MHz.
	input  wire       RESET_I,			// Synchronous reset, active high.
	// Register port from the host serial interface.
	input  wire       REG_WR_I,			// Write strobe, one cycle.
	input  wire       REG_RD_I,			// Read strobe, one cycle.
	input  wire [7:0] REG_ADDR_I,			// Register offset.
	input  wire [7:0] REG_WDATA_I,			// Write data.
	output reg  [7:0] REG_RDATA_O,			// Read data.
	output reg        REG_RVALID_O,			// Read data valid, one cycle.
	// Sources for the shared pins.
	input  wire       FIELD_IDENTIFIER_I,		// Field ID from the timing logic.
	input  wire       GENLOCK_SERIAL_OUT_I,		// Serial subcarrier stream.
	input  wire       HV_LOCK_I,			// Horizontal and vertical lock.
	input  wire       VSYNC_I,			// Vertical sync.
	input  wire       PAL_INDICATOR_I,		// PAL line indicator.
	input  wire       INTERRUPT_REQUEST_I,		// Interrupt request level.
	input  wire       GP_DATA_I,			// General-purpose output data.
	input  wire       VERTICAL_BLANK_I,		// Vertical blank level.
	input  wire       VBLANK_PIN_SELECT_I,		// Misc control bit 7.
	input  wire       SAMPLE_CLK_I,			// Sample clock level.
	input  wire       PIXEL_CLK_I,			// Pixel clock level.
	input  wire       ACTIVE_VIDEO_I,		// Unmasked active video.
	// Shared pin outputs.
	output reg        FIELD_PIN_O,			// Field-ID / genlock pin.
	output reg        VSYNC_PIN_O,			// Vsync / PAL flag pin.
	output reg        GENERAL_PURPOSE_PIN_O,	// Interrupt / general / vblank pin.
	output reg        CLOCK_PIN_O,			// Sample / pixel clock pin.
	output reg        ACTIVE_VIDEO_FLAG_O,		// Masked active video flag.
	// Settings for the datapath.
	output reg        LUMA_TRAP_SEL_O,		// 1: chroma trap, 0: comb.
	output reg  [2:0] PEAK_GAIN_X2_O,		// Peaking gain times two.
	output reg  [7:0] BRIGHTNESS_O,			// Brightness code.
	output reg  [7:0] SATURATION_O,			// Saturation code.
	output reg  [7:0] HUE_O,			// Signed hue rotation.
	output reg  [7:0] CONTRAST_O,			// Contrast code.
	output reg  [7:0] Y_MIN_O,			// Lowest luma code.
	output reg  [7:0] Y_MAX_O,			// Highest luma code.
	output reg  [7:0] C_MIN_O,			// Lowest chroma code.
	output reg  [7:0] C_MAX_O,			// Highest chroma code.
	output reg  [7:0] CHROMA_OFFSET_O,		// Added to two's complement chroma.
	output reg  [1:0] BYPASS_O,			// Data path bypass mode.
	output reg        EMBEDDED_SYNC_O,		// 1: embedded syncs, 0: discrete.
	output reg  [1:0] STOPBAND_O,			// Chroma trap notch select.
	output reg  [9:0] CROP_START_O,			// Applied signed start position.
	output reg  [9:0] CROP_STOP_O,			// Applied signed stop position.
	output reg        OSCILLATOR_INCREMENT_LSB_O,	// Forced LSB of colour increment.
	output reg        RTC_FORMAT_O			// 1: real-time, 0: genlock format.
);

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	reg  [7:0] luma_control_two_r;		// Luma filter and peaking.
	reg  [7:0] brightness_level_r;		// Brightness.
	reg  [7:0] colour_saturation_r;		// Saturation.
	reg  [7:0] hue_phase_r;			// Hue.
	reg  [7:0] contrast_level_r;		// Contrast.
	reg  [7:0] output_format_select_r;	// Range, UV format, bypass, format.
	reg  [7:0] shared_pin_config_r;		// Shared pins and luma stopband.
	reg  [7:0] genlock_rtc_control_r;	// Oscillator LSB and serial format.
	wire [7:0] start_upper;			// Staged start bits 9:2.
	wire [7:0] start_lower;			// Start lower register.
	wire [9:0] start_position;		// Applied start position.
	wire [7:0] stop_upper;			// Staged stop bits 9:2.
	wire [7:0] stop_lower;			// Stop lower register.
	wire [9:0] stop_position;		// Applied stop position.
	reg  [7:0] rdata_nxt;			// Read mux result.

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	// Address match for one write strobe.
	function wr_hit;
		input       wr;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			wr_hit = wr & (addr == ofs);
		end
	endfunction

	// Peaking gain code to gain times two, so 0.5 stays an integer.
	function [2:0] peak_gain_x2;
		input [1:0] code;
		begin
			case (code)
				2'h0:    peak_gain_x2 = `GAIN_X2_ZERO;
				2'h1:    peak_gain_x2 = `GAIN_X2_HALF;
				2'h2:    peak_gain_x2 = `GAIN_X2_ONE;
				default: peak_gain_x2 = `GAIN_X2_TWO;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	// Reserved bits are masked on the way in so that they read as zero.
	// The luma stopband field and the shared-pin register answer at the
	// same offset, so they share one storage byte.
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			luma_control_two_r     <= `RST_LUMA_CONTROL_TWO;
			brightness_level_r     <= `RST_BRIGHTNESS_LEVEL;
			colour_saturation_r    <= `RST_COLOUR_SATURATION;
			hue_phase_r            <= `RST_HUE_PHASE;
			contrast_level_r       <= `RST_CONTRAST_LEVEL;
			output_format_select_r <= `RST_OUTPUT_FORMAT_SELECT;
			shared_pin_config_r    <= `RST_SHARED_PIN_CONFIG;
			genlock_rtc_control_r  <= `RST_GENLOCK_RTC_CONTROL;
		end else begin
			if (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_LUMA_CONTROL_TWO)) begin
				luma_control_two_r <= REG_WDATA_I & `MSK_LUMA_CONTROL_TWO;
			end
			if (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_BRIGHTNESS_LEVEL)) begin
				brightness_level_r <= REG_WDATA_I;
			end
			if (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_COLOUR_SATURATION)) begin
				colour_saturation_r <= REG_WDATA_I;
			end
			if (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_HUE_PHASE)) begin
				hue_phase_r <= REG_WDATA_I;
			end
			if (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_CONTRAST_LEVEL)) begin
				contrast_level_r <= REG_WDATA_I;
			end
			if (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_OUTPUT_FORMAT_SELECT)) begin
				output_format_select_r <= REG_WDATA_I & `MSK_OUTPUT_FORMAT_SELECT;
			end
			if (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_SHARED_PIN_CONFIG)) begin
				shared_pin_config_r <= REG_WDATA_I & `MSK_SHARED_PIN_CONFIG;
			end
			if (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_GENLOCK_RTC_CONTROL)) begin
				genlock_rtc_control_r <= REG_WDATA_I & `MSK_GENLOCK_RTC_CONTROL;
			end
		end
	end

	// ------------------------------------------------------------------
	// Cropping positions
	// ------------------------------------------------------------------
	// signed start position
	crop_position_stage #(
		.LOWER_MASK (`MSK_CROP_START_LOWER)
	) start_stage (
		.clk_i      (CLK_SYS_I),
		.reset_i    (RESET_I),
		.wr_upper_i (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_CROP_START_UPPER)),
		.wr_lower_i (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_CROP_START_LOWER)),
		.wdata_i    (REG_WDATA_I),
		.upper_r    (start_upper),
		.lower_r    (start_lower),
		.position_r (start_position)
	);

	crop_position_stage #(
		.LOWER_MASK (`MSK_CROP_STOP_LOWER)
	) stop_stage (
		.clk_i      (CLK_SYS_I),
		.reset_i    (RESET_I),
		.wr_upper_i (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_CROP_STOP_UPPER)),
		.wr_lower_i (wr_hit(REG_WR_I, REG_ADDR_I, `OFS_CROP_STOP_LOWER)),
		.wdata_i    (REG_WDATA_I),
		.upper_r    (stop_upper),
		.lower_r    (stop_lower),
		.position_r (stop_position)
	);

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	// Unmapped offsets read as zero rather than holding the last value.
	always @* begin
		case (REG_ADDR_I)
			`OFS_LUMA_CONTROL_TWO:     rdata_nxt = luma_control_two_r;
			`OFS_BRIGHTNESS_LEVEL:     rdata_nxt = brightness_level_r;
			`OFS_COLOUR_SATURATION:    rdata_nxt = colour_saturation_r;
			`OFS_HUE_PHASE:            rdata_nxt = hue_phase_r;
			`OFS_CONTRAST_LEVEL:       rdata_nxt = contrast_level_r;
			`OFS_OUTPUT_FORMAT_SELECT: rdata_nxt = output_format_select_r;
			`OFS_SHARED_PIN_CONFIG:    rdata_nxt = shared_pin_config_r;
			`OFS_CROP_START_UPPER:     rdata_nxt = start_upper;
			`OFS_CROP_START_LOWER:     rdata_nxt = start_lower;
			`OFS_CROP_STOP_UPPER:      rdata_nxt = stop_upper;
			`OFS_CROP_STOP_LOWER:      rdata_nxt = stop_lower;
			`OFS_GENLOCK_RTC_CONTROL:  rdata_nxt = genlock_rtc_control_r;
			default:                   rdata_nxt = 8'h00;
		endcase
	end

	// Read data is registered; valid follows the strobe by one cycle.
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			REG_RDATA_O  <= 8'h00;
			REG_RVALID_O <= 1'b0;
		end else begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I) begin
				REG_RDATA_O <= rdata_nxt;
			end
		end
	end

	// ------------------------------------------------------------------
	// Shared pin routing and active video mask
	// ------------------------------------------------------------------
	// All pins are registered, so each adds one cycle of delay. A clock
	// routed this way is only a sampled level; a real clock pin would
	// need a glitch-free clock mux instead.
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			FIELD_PIN_O           <= 1'b0;
			VSYNC_PIN_O           <= 1'b0;
			GENERAL_PURPOSE_PIN_O <= 1'b0;
			CLOCK_PIN_O           <= 1'b0;
			ACTIVE_VIDEO_FLAG_O   <= 1'b0;
		end else begin
			if (shared_pin_config_r[`BIT_FIELD_PIN_GENLOCK]) begin
				FIELD_PIN_O <= GENLOCK_SERIAL_OUT_I;
			end else if (shared_pin_config_r[`BIT_FIELD_PIN_LOCK]) begin
				FIELD_PIN_O <= HV_LOCK_I;
			end else begin
				FIELD_PIN_O <= FIELD_IDENTIFIER_I;
			end
			if (shared_pin_config_r[`BIT_VSYNC_PIN_PAL]) begin
				VSYNC_PIN_O <= shared_pin_config_r[`BIT_PAL_PIN_LOCK] ?
					HV_LOCK_I : PAL_INDICATOR_I;
			end else begin
				VSYNC_PIN_O <= shared_pin_config_r[`BIT_VSYNC_PIN_LOCK] ?
					HV_LOCK_I : VSYNC_I;
			end
			if (shared_pin_config_r[`BIT_GP_PIN_ALT]) begin
				GENERAL_PURPOSE_PIN_O <= VBLANK_PIN_SELECT_I ?
					VERTICAL_BLANK_I : GP_DATA_I;
			end else begin
				GENERAL_PURPOSE_PIN_O <= INTERRUPT_REQUEST_I;
			end
			CLOCK_PIN_O <= shared_pin_config_r[`BIT_CLK_PIN_PIXEL] ?
				PIXEL_CLK_I : SAMPLE_CLK_I;
			ACTIVE_VIDEO_FLAG_O <= ACTIVE_VIDEO_I &
				~(start_lower[`BIT_ACTIVE_VIDEO_FLAG_OFF_IN_VERTICAL_BLANK_OUT] & VERTICAL_BLANK_I);
		end
	end

	// ------------------------------------------------------------------
	// Datapath settings
	// ------------------------------------------------------------------
	// Decoded settings are registered so the datapath sees clean levels.
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			LUMA_TRAP_SEL_O            <= 1'b0;
			PEAK_GAIN_X2_O             <= `GAIN_X2_ZERO;
			BRIGHTNESS_O               <= `RST_BRIGHTNESS_LEVEL;
			SATURATION_O               <= `RST_COLOUR_SATURATION;
			HUE_O                      <= `RST_HUE_PHASE;
			CONTRAST_O                 <= `RST_CONTRAST_LEVEL;
			Y_MIN_O                    <= `RANGE_MIN_EXT;
			Y_MAX_O                    <= `RANGE_MAX_EXT;
			C_MIN_O                    <= `RANGE_MIN_EXT;
			C_MAX_O                    <= `RANGE_MAX_EXT;
			CHROMA_OFFSET_O            <= `CHROMA_OFFSET;
			BYPASS_O                   <= `BYPASS_NORMAL;
			EMBEDDED_SYNC_O            <= 1'b1;
			STOPBAND_O                 <= 2'h0;
			CROP_START_O               <= `RST_CROP_POSITION;
			CROP_STOP_O                <= `RST_CROP_POSITION;
			OSCILLATOR_INCREMENT_LSB_O <= 1'b1;
			RTC_FORMAT_O               <= 1'b1;
		end else begin
			LUMA_TRAP_SEL_O <= luma_control_two_r[`BIT_LUMA_TRAP_SEL];
			PEAK_GAIN_X2_O <= peak_gain_x2(
				luma_control_two_r[`FLD_PEAK_GAIN_HI:`FLD_PEAK_GAIN_LO]);
			BRIGHTNESS_O <= brightness_level_r;
			SATURATION_O <= colour_saturation_r;
			HUE_O <= hue_phase_r;
			CONTRAST_O <= contrast_level_r;
			if (output_format_select_r[`BIT_EXT_RANGE]) begin
				Y_MIN_O <= `RANGE_MIN_EXT;
				Y_MAX_O <= `RANGE_MAX_EXT;
				C_MIN_O <= `RANGE_MIN_EXT;
				C_MAX_O <= `RANGE_MAX_EXT;
			end else begin
				Y_MIN_O <= `RANGE_Y_MIN_601;
				Y_MAX_O <= `RANGE_Y_MAX_601;
				C_MIN_O <= `RANGE_C_MIN_601;
				C_MAX_O <= `RANGE_C_MAX_601;
			end
			CHROMA_OFFSET_O <= output_format_select_r[`BIT_UV_TWOS] ?
				8'h00 : `CHROMA_OFFSET;
			case (output_format_select_r[`FLD_BYPASS_HI:`FLD_BYPASS_LO])
				`BYPASS_DECIMATION: BYPASS_O <= `BYPASS_DECIMATION;
				`BYPASS_RAW_ADC:    BYPASS_O <= `BYPASS_RAW_ADC;
				default:            BYPASS_O <= `BYPASS_NORMAL;
			endcase
			EMBEDDED_SYNC_O <= (output_format_select_r[`FLD_FORMAT_HI:`FLD_FORMAT_LO]
				!= `FORMAT_DISCRETE_SYNC);
			STOPBAND_O <= shared_pin_config_r[`FLD_STOPBAND_HI:`FLD_STOPBAND_LO];
			CROP_START_O <= start_position;
			CROP_STOP_O <= stop_position;
			OSCILLATOR_INCREMENT_LSB_O <= genlock_rtc_control_r[`BIT_OSC_LSB_FORCE];
			RTC_FORMAT_O <= genlock_rtc_control_r[`BIT_RTC_SELECT];
		end
	end

endmodule // picture_ctrl_regs

// File: testbench/picture_ctrl_props.sv
// Concurrent checks on the picture control bank, bound to its top module.
`timescale 1ns/1ps

module picture_ctrl_props (
	input wire       CLK_SYS_I, RESET_I, REG_WR_I, REG_RD_I, REG_RVALID_O,
	input wire [7:0] REG_ADDR_I, REG_WDATA_I,
	input wire       FIELD_IDENTIFIER_I, GENLOCK_SERIAL_OUT_I, HV_LOCK_I, VSYNC_I,
	input wire       PAL_INDICATOR_I, INTERRUPT_REQUEST_I, GP_DATA_I, VERTICAL_BLANK_I,
	input wire       VBLANK_PIN_SELECT_I, SAMPLE_CLK_I, PIXEL_CLK_I, ACTIVE_VIDEO_I,
	input wire       FIELD_PIN_O, VSYNC_PIN_O, GENERAL_PURPOSE_PIN_O, CLOCK_PIN_O,
	input wire       ACTIVE_VIDEO_FLAG_O,
	input wire [9:0] CROP_START_O, CROP_STOP_O
);
	// ------------------------------------------------------------
	// Shadow state
	// ------------------------------------------------------------
	reg  [7:0] cfg_r, up_start_r, up_stop_r;	// Shared-pin byte and staged upper bytes.
	reg        av_off_r;				// Active video off in blanking.
	reg  [9:0] exp_start_r, exp_stop_r;		// Positions due at the outputs.
	wire       wr_start = REG_WR_I && REG_ADDR_I == 8'h12;
	wire       wr_stop  = REG_WR_I && REG_ADDR_I == 8'h14;
	wire       field_w = cfg_r[3] ? GENLOCK_SERIAL_OUT_I : (cfg_r[6] ? HV_LOCK_I : FIELD_IDENTIFIER_I);
	wire       vs_w = cfg_r[2] ? (cfg_r[4] ? HV_LOCK_I : PAL_INDICATOR_I) : (cfg_r[5] ? HV_LOCK_I : VSYNC_I);
	wire       gp_w = cfg_r[1] ? (VBLANK_PIN_SELECT_I ? VERTICAL_BLANK_I : GP_DATA_I) : INTERRUPT_REQUEST_I;
	wire       ck_w = cfg_r[0] ? PIXEL_CLK_I : SAMPLE_CLK_I;
	wire       av_w = ACTIVE_VIDEO_I & ~(av_off_r & VERTICAL_BLANK_I);

	// Mirrors the writes; the upper byte is taken as held before the lower write.
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			cfg_r <= 8'h08;
			up_start_r <= 8'h00;
			up_stop_r <= 8'h00;
			av_off_r <= 1'b0;
			exp_start_r <= 10'h000;
			exp_stop_r <= 10'h000;
		end else begin
			if (REG_WR_I && REG_ADDR_I == 8'h0f) cfg_r <= REG_WDATA_I;
			if (REG_WR_I && REG_ADDR_I == 8'h11) up_start_r <= REG_WDATA_I;
			if (REG_WR_I && REG_ADDR_I == 8'h13) up_stop_r <= REG_WDATA_I;
			if (wr_start) av_off_r <= REG_WDATA_I[2];
			if (wr_start) exp_start_r <= {up_start_r, REG_WDATA_I[1:0]};
			if (wr_stop) exp_stop_r <= {up_stop_r, REG_WDATA_I[1:0]};
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);

	// A lower write followed by two quiet cycles.
	sequence s_start_wr; wr_start ##1 !wr_start ##1 !wr_start; endsequence
	sequence s_stop_wr; wr_stop ##1 !wr_stop ##1 !wr_stop; endsequence

	property p_field_pin; !$past(RESET_I) |-> FIELD_PIN_O == $past(field_w); endproperty
	property p_vsync_pin; !$past(RESET_I) |-> VSYNC_PIN_O == $past(vs_w); endproperty
	property p_gp_pin; !$past(RESET_I) |-> GENERAL_PURPOSE_PIN_O == $past(gp_w); endproperty
	property p_clk_pin; !$past(RESET_I) |-> CLOCK_PIN_O == $past(ck_w); endproperty
	property p_av_flag; !$past(RESET_I) |-> ACTIVE_VIDEO_FLAG_O == $past(av_w); endproperty
	property p_start_hold; !$past(RESET_I) && !$past(wr_start, 2) |-> $stable(CROP_START_O);
	endproperty
	property p_start_val; s_start_wr |=> CROP_START_O == exp_start_r; endproperty
	property p_stop_val; s_stop_wr |=> CROP_STOP_O == exp_stop_r; endproperty
	property p_read; REG_RVALID_O == ($past(REG_RD_I) && !$past(RESET_I)); endproperty

	a_field_pin: assert property (p_field_pin) else $error("field pin source wrong");
	a_vsync_pin: assert property (p_vsync_pin) else $error("vsync pin source wrong");
	a_gp_pin: assert property (p_gp_pin) else $error("general pin source wrong");
	a_clk_pin: assert property (p_clk_pin) else $error("clock pin source wrong");
	a_av_flag: assert property (p_av_flag) else $error("active video flag wrong");
	a_start_hold: assert property (p_start_hold) else $error("start moved early");
	a_start_val: assert property (p_start_val) else $error("start value wrong");
	a_stop_val: assert property (p_stop_val) else $error("stop value wrong");
	a_read: assert property (p_read) else $error("read valid timing wrong");
endmodule // picture_ctrl_props

bind picture_ctrl_regs picture_ctrl_props u_props (.*);

// File: testbench/picture_ctrl_regs_tb_top.sv
// Self-checking bench of the picture control register bank.
`timescale 1ns/1ps

module picture_ctrl_regs_tb_top;
	// ------------------------------------------------------------
	// Signals and tables
	// ------------------------------------------------------------
	localparam [111:0] OFS = 112'hff1015141312110f0d0c0b0a0908;
	localparam [111:0] RST = 112'h0000050000000008478000808000;
	localparam [111:0] MSK = 112'h00000503ff07ff7f7fffffffff4c;
	localparam [11:0]  GN  = {3'h4, 3'h2, 3'h1, 3'h0};	// Gain times two per code.
	reg         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	reg  [7:0]  addr = 8'h00, wd = 8'h00;
	reg  [11:0] pin = 12'h000;	// Random levels for the pin sources.
	reg  [31:0] lf = 32'h3fea;	// Random state, moved on falling edges only.
	reg  [7:0]  dv [0:13];		// Values written in the random pass.
	reg  [7:0]  expq [$];		// Expected read data, oldest first.
	integer     fails = 0, num_checks = 0, i;
	wire [7:0]  rdata, coff;
	wire [31:0] pic, rng;
	wire [9:0]  cst, csp;
	wire [2:0]  gain;
	wire [1:0]  byp, stp;
	wire        rvalid, trap, emb, osc, rtc;

	picture_ctrl_regs dut (.CLK_SYS_I(clk), .RESET_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.FIELD_IDENTIFIER_I(pin[0]), .GENLOCK_SERIAL_OUT_I(pin[1]), .HV_LOCK_I(pin[2]),
		.VSYNC_I(pin[3]), .PAL_INDICATOR_I(pin[4]), .INTERRUPT_REQUEST_I(pin[5]),
		.GP_DATA_I(pin[6]), .VERTICAL_BLANK_I(pin[7]), .VBLANK_PIN_SELECT_I(pin[8]),
		.SAMPLE_CLK_I(pin[9]), .PIXEL_CLK_I(pin[10]), .ACTIVE_VIDEO_I(pin[11]),
		.FIELD_PIN_O(), .VSYNC_PIN_O(), .GENERAL_PURPOSE_PIN_O(), .CLOCK_PIN_O(),
		.ACTIVE_VIDEO_FLAG_O(), .LUMA_TRAP_SEL_O(trap), .PEAK_GAIN_X2_O(gain),
		.BRIGHTNESS_O(pic[31:24]), .SATURATION_O(pic[23:16]), .HUE_O(pic[15:8]),
		.CONTRAST_O(pic[7:0]), .Y_MIN_O(rng[31:24]), .Y_MAX_O(rng[23:16]),
		.C_MIN_O(rng[15:8]), .C_MAX_O(rng[7:0]), .CHROMA_OFFSET_O(coff), .BYPASS_O(byp),
		.EMBEDDED_SYNC_O(emb), .STOPBAND_O(stp), .CROP_START_O(cst), .CROP_STOP_O(csp),
		.OSCILLATOR_INCREMENT_LSB_O(osc), .RTC_FORMAT_O(rtc));

	always #25 clk = ~clk;

	// Random state moves on the falling edge so readers never race it.
	always @(negedge clk) lf <= {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};

	// Pin sources get fresh random levels just after every rising edge.
	always @(posedge clk) pin <= #1 lf[11:0];

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
			end
		end
	endtask

	// One bus cycle; each call holds the strobes for exactly one edge.
	task bus(input w, input r, input [7:0] a, input [7:0] d);
		begin
			{wr, rd, addr, wd} = {w, r, a, d};
			@(posedge clk);
			#1;
		end
	endtask

	task rdx(input [7:0] a, input [7:0] e);
		begin
			expq.push_back(e);
			bus(1'b0, 1'b1, a, 8'h00);
		end
	endtask

	task idle2;
		begin
			bus(1'b0, 1'b0, 8'h00, 8'h00);
			bus(1'b0, 1'b0, 8'h00, 8'h00);
		end
	endtask

	task test_done;
		begin
			$display("comparisons %0d, mismatches %0d", num_checks, fails);
			if (fails == 0 && num_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	// Read answers are matched against the oldest expected note.
	always @(posedge clk) if (rvalid === 1'b1) chk(rdata, expq.pop_front());

	// Watchdog: the sequence needs about 1150 cycles.
	initial begin
		#(20000 * 50);
		fails = fails + 1;
		test_done;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		for (i = 0; i < 14; i = i + 1) rdx(OFS[8*i +: 8], RST[8*i +: 8]);
		chk(pic, 32'h80800080);
		chk(rng, 32'h01fe01fe);
		chk({coff, emb, osc, rtc, cst, csp}, {8'h80, 3'h7, 20'h0});
		$display("reset values done");
		for (i = 0; i < 13; i = i + 1) begin
			dv[i] = lf[7:0];
			bus(1'b1, 1'b0, OFS[8*i +: 8], dv[i]);
		end
		for (i = 0; i < 14; i = i + 1) rdx(OFS[8*i +: 8], dv[i] & MSK[8*i +: 8]);
		idle2;
		chk(pic, {dv[1], dv[2], dv[3], dv[4]});
		chk({cst, csp}, {dv[7], dv[8][1:0], dv[9], dv[10][1:0]});
		$display("random access done");
		for (i = 0; i < 4; i = i + 1) begin
			bus(1'b1, 1'b0, 8'h08, {1'b0, i[0], 2'b00, i[1:0], 2'b00});
			bus(1'b1, 1'b0, 8'h0f, {6'h00, i[1:0]});
			bus(1'b1, 1'b0, 8'h15, {5'h00, i[0], 1'b0, i[1]});
			idle2;
			chk(gain, GN[3*i +: 3]);
			chk(trap, i[0]);
			chk(stp, i[1:0]);
			chk({osc, rtc}, {i[0], i[1]});
		end
		for (i = 0; i < 8; i = i + 1) begin
			bus(1'b1, 1'b0, 8'h0d, {1'b0, i[0], i[1], i[1:0], i[2:0]});
			idle2;
			chk(rng, i[0] ? 32'h01fe01fe : 32'h10eb10f0);
			chk(coff, i[1] ? 8'h00 : 8'h80);
			chk(byp, (i[1:0] == 2'h3) ? 2'h0 : i[1:0]);
			chk(emb, i[2:0] != 3'h0);
		end
		$display("settings done");
		bus(1'b1, 1'b0, 8'h11, 8'h80);
		idle2;
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		chk(cst, {dv[7], dv[8][1:0]});
		bus(1'b1, 1'b0, 8'h12, 8'h00);
		bus(1'b1, 1'b0, 8'h13, 8'h7f);
		bus(1'b1, 1'b0, 8'h14, 8'h02);
		idle2;
		chk({cst, csp}, {10'h200, 10'h1fe});
		$display("cropping done");
		for (i = 0; i < 256; i = i + 1) begin
			bus(1'b1, 1'b0, 8'h0f, i[7:0]);
			bus(1'b1, 1'b0, 8'h12, {5'h00, i[0], 2'b00});
			idle2;
		end
		$display("pin routing done");
		idle2;
		test_done;
	end
endmodule // picture_ctrl_regs_tb_top
